// *** rtl/servo_param_sequence_config.sv ***
// servo parameter set: registers, input forcing, command offset, brake sequencing
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
module servo_param_sequence_config #(
  parameter int TICK_10MS_CYCLES = servo_cfg_pkg::TICK_10MS_DEF
) (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SERVO_ON_I,
  input wire logic PULSE_BLOCK_I,
  input wire logic MANUAL_FORWARD_I,
  input wire logic MANUAL_REVERSE_I,
  input wire logic MULTISTEP_SEL_LO_I,
  input wire logic MULTISTEP_SEL_HI_I,
  input wire logic COMP_SEL_LO_I,
  input wire logic COMP_SEL_HI_I,
  input wire logic OVERTRAVEL_I,
  input wire logic [servo_cfg_pkg::CMD_W-1:0] ADC_DATA_I,
  input wire logic [4:0] RX_ADDR_I,
  input wire logic RX_ADDR_VALID_I,
  output logic [servo_cfg_pkg::CMD_W-1:0] CMD_O,
  output logic SERVO_ON_O,
  output logic PULSE_BLOCK_O,
  output logic MANUAL_FORWARD_O,
  output logic MANUAL_REVERSE_O,
  output logic MULTISTEP_SEL_LO_O,
  output logic MULTISTEP_SEL_HI_O,
  output logic [servo_cfg_pkg::FACT_W-1:0] COMP_FACTOR_O,
  output logic POWER_STAGE_ON_O,
  output logic DYNAMIC_BRAKE_O,
  output logic ADDR_MATCH_O,
  output logic BAUD_TICK_O,
  output logic [4:0] STATION_O
);
  import servo_cfg_pkg::*;

  function automatic logic [31:0] sat(input logic signed [31:0] v, input int lo, input int hi);
    if (v < lo) begin
      sat = lo;
    end else if (v > hi) begin
      sat = hi;
    end else begin
      sat = v;
    end
  endfunction

  function automatic logic is_forced(input logic [19:0] slots, input logic [4:0] code);
    is_forced = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (slots[i*5 +: 5] == code) begin
        is_forced = 1'b1;
      end
    end
  endfunction

  // settings
  logic signed [OFS_W-1:0] offset_ff;
  logic [1:0] dbseq_ff;
  logic [1:0] act_dbseq_ff;
  logic [9:0] brake_ff;
  logic [19:0] force_ff;
  logic [19:0] act_force_ff;
  logic [FACT_W-1:0] fact_ff [4];
  logic [6:0] ramcnt_ff;
  logic [6:0] act_ramcnt_ff;
  logic [4:0] station_ff;
  logic [4:0] act_station_ff;
  logic [1:0] baud_ff;
  logic [1:0] act_baud_ff;
  logic [10:0] travel_ff;
  logic [15:0] speed_ff;
  logic [8:0] timer_ff;
  logic [1:0] mode_ff;
  logic test_ff;
  logic [NV_W-1:0] nv_count_ff;

  // bus
  logic ready_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic [5:0] idx;
  logic setup;
  logic wr;
  logic mapped;
  logic signed [31:0] wval;

  // inputs
  logic [SEQ_N-1:0] seq_meta_ff;
  logic [SEQ_N-1:0] seq_sync_ff;
  logic fwd_prev_ff;
  logic rev_prev_ff;
  logic pos_mode;
  logic eff_servo;
  logic eff_fwd;
  logic eff_rev;
  logic power_on;
  logic baud_tick;
  logic [1:0] cmp_sel;
  logic signed [31:0] cmd_sum;

  assign idx = PADDR_I[7:2];
  assign setup = PSEL_I && !PENABLE_I;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I && ready_ff;
  assign mapped = (idx <= IDX_ACTIVE);
  assign wval = $signed(PWDATA_I);
  assign pos_mode = (mode_ff == MODE_POS);

  // two flops on every sequence input pin before any logic reads it
  always_ff @(posedge CLK_I) begin
    seq_meta_ff <= {OVERTRAVEL_I, COMP_SEL_HI_I, COMP_SEL_LO_I, MULTISTEP_SEL_HI_I, MULTISTEP_SEL_LO_I,
                    MANUAL_REVERSE_I, MANUAL_FORWARD_I, PULSE_BLOCK_I, SERVO_ON_I};
    seq_sync_ff <= seq_meta_ff;
  end

  // forced slots act through their power-up copy only
  assign eff_servo = seq_sync_ff[SEQ_SERVO] || is_forced(act_force_ff, CODE_SERVO);
  // manual commands are never held on in position control
  assign eff_fwd = seq_sync_ff[SEQ_FWD] || (!pos_mode && is_forced(act_force_ff, CODE_FWD));
  assign eff_rev = seq_sync_ff[SEQ_REV] || (!pos_mode && is_forced(act_force_ff, CODE_REV));
  assign cmp_sel = {seq_sync_ff[SEQ_CMP_HI], seq_sync_ff[SEQ_CMP_LO]};

  // apb slave: setup cycle latches the answer, access phase lasts one cycle
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ready_ff <= 1'b0;
      slverr_ff <= 1'b0;
    end else if (setup) begin
      ready_ff <= 1'b1;
      slverr_ff <= !mapped;
    end else begin
      ready_ff <= 1'b0;
      slverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rdata_ff <= '0;
    end else if (setup && !PWRITE_I) begin
      case (idx)
        IDX_OFFSET: rdata_ff <= 32'(signed'(offset_ff));
        IDX_DBSEQ: rdata_ff <= {30'h0000_0000, dbseq_ff};
        IDX_BRAKE: rdata_ff <= {22'h00_0000, brake_ff};
        IDX_FORCE: rdata_ff <= {3'h0, force_ff[19:15], 3'h0, force_ff[14:10], 3'h0, force_ff[9:5],
                                3'h0, force_ff[4:0]};
        IDX_RAMCNT: rdata_ff <= {25'h000_0000, ramcnt_ff};
        IDX_STATION: rdata_ff <= {27'h000_0000, station_ff};
        IDX_BAUD: rdata_ff <= {30'h0000_0000, baud_ff};
        IDX_TRAVEL: rdata_ff <= {21'h00_0000, travel_ff};
        IDX_SPEED: rdata_ff <= {16'h0000, speed_ff};
        IDX_TIMER: rdata_ff <= {23'h00_0000, timer_ff};
        IDX_CTRL: rdata_ff <= {27'h000_0000, 1'b0, test_ff, mode_ff, 1'b0};
        IDX_STATUS: rdata_ff <= {7'h00, (nv_count_ff >= NV_W'(NV_LIMIT)), nv_count_ff, power_on,
                                 DYNAMIC_BRAKE_O, eff_servo, act_dbseq_ff, act_baud_ff};
        IDX_ACTIVE: rdata_ff <= {act_ramcnt_ff, 3'h0, act_station_ff, 2'h0, COMP_FACTOR_O};
        default: begin
          if (idx >= IDX_FACT0 && idx <= IDX_FACT3) begin
            rdata_ff <= {17'h0_0000, fact_ff[idx[1:0]]};
          end else begin
            rdata_ff <= '0;
          end
        end
      endcase
    end
  end

  assign PRDATA_O = rdata_ff;
  assign PREADY_O = ready_ff;
  assign PSLVERR_O = slverr_ff;

  // analog offset: software write, or auto trim from the live input in test mode
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      offset_ff <= OFS_W'(OFS_FACTORY_DEF);
    end else if (wr && idx == IDX_CTRL && PWDATA_I[CTRL_AUTO_OFS] && test_ff) begin
      offset_ff <= OFS_W'(sat(-32'(signed'(ADC_DATA_I)), OFS_MIN, OFS_MAX));
    end else if (wr && idx == IDX_OFFSET) begin
      offset_ff <= OFS_W'(sat(wval, OFS_MIN, OFS_MAX));
    end
  end

  // one offset step equals one converter lsb within 1 percent, so they add directly
  assign cmd_sum = 32'(signed'(ADC_DATA_I)) + 32'(signed'(offset_ff));
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      CMD_O <= '0;
    end else begin
      CMD_O <= CMD_W'(sat(cmd_sum, CMD_MIN, CMD_MAX));
    end
  end

  // stored copies of settings
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      dbseq_ff <= 2'(DBSEQ_DEF);
      brake_ff <= '0;
      force_ff <= '0;
      ramcnt_ff <= '0;
      station_ff <= 5'(STATION_MIN);
      baud_ff <= '0;
      travel_ff <= 11'(TRAVEL_DEF);
      speed_ff <= 16'(SPEED_DEF);
      timer_ff <= 9'(TIMER_DEF);
      mode_ff <= MODE_POS;
      test_ff <= 1'b0;
    end else if (wr) begin
      case (idx)
        IDX_DBSEQ: dbseq_ff <= PWDATA_I[1:0];
        IDX_BRAKE: brake_ff <= 10'(sat(wval, 0, BRAKE_MAX));
        IDX_FORCE: begin
          for (int i = 0; i < 4; i++) begin
            force_ff[i*5 +: 5] <= 5'(sat(32'(PWDATA_I[i*8 +: 5]), 0, SLOT_MAX));
          end
        end
        IDX_RAMCNT: ramcnt_ff <= 7'(sat(wval, 0, RAMCNT_MAX));
        IDX_STATION: station_ff <= 5'(sat(wval, STATION_MIN, STATION_MAX));
        IDX_BAUD: baud_ff <= 2'(sat(wval, 0, BAUD_MAX));
        IDX_TRAVEL: travel_ff <= 11'(sat(wval, TRAVEL_MIN, TRAVEL_MAX));
        IDX_SPEED: speed_ff <= 16'(sat(wval, SPEED_MIN, SPEED_MAX));
        IDX_TIMER: timer_ff <= 9'(sat(wval, TIMER_MIN, TIMER_MAX));
        IDX_CTRL: begin
          mode_ff <= PWDATA_I[CTRL_MODE_LO +: 2];
          test_ff <= PWDATA_I[CTRL_TEST];
        end
        default: begin
        end
      endcase
    end
  end

  // compensation factors; all four reset to 1, which also covers the ram-held ones
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      for (int i = 0; i < 4; i++) begin
        fact_ff[i] <= FACT_W'(FACT_MIN);
      end
    end else if (wr && idx >= IDX_FACT0 && idx <= IDX_FACT3) begin
      fact_ff[idx[1:0]] <= FACT_W'(sat(wval, FACT_MIN, FACT_MAX));
    end
  end

  // rewrites that reach non-volatile storage wear it; ram-held factors do not count
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      nv_count_ff <= '0;
    end else if (wr && idx <= IDX_TIMER && nv_count_ff != '1) begin
      if (idx == IDX_FACT0 && act_ramcnt_ff >= 7'(LIST_POS_FACT0)) begin
        nv_count_ff <= nv_count_ff;
      end else if (idx > IDX_FACT0 && idx <= IDX_FACT3 &&
                   act_ramcnt_ff >= 7'(LIST_POS_FACT1 + 32'(idx - IDX_FACT0) - 1)) begin
        nv_count_ff <= nv_count_ff;
      end else begin
        nv_count_ff <= nv_count_ff + 1'b1;
      end
    end
  end

  // power-class settings go live at reset or on the reload strobe, which stands in for power-up
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      act_dbseq_ff <= 2'(DBSEQ_DEF);
      act_force_ff <= '0;
      act_ramcnt_ff <= '0;
      act_station_ff <= 5'(STATION_MIN);
      act_baud_ff <= '0;
    end else if (wr && idx == IDX_CTRL && PWDATA_I[CTRL_RELOAD]) begin
      act_dbseq_ff <= dbseq_ff;
      act_force_ff <= force_ff;
      act_ramcnt_ff <= ramcnt_ff;
      act_station_ff <= station_ff;
      act_baud_ff <= baud_ff;
    end
  end

  brake_delay_timer #(
    .TICK_CYCLES(TICK_10MS_CYCLES)
  ) u_brake (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .servo_on_i(eff_servo),
    .delay_i(brake_ff),
    .power_on_o(power_on)
  );

  baud_tick_gen u_baud (
    .clk_i(CLK_I),
    .resetn_i(RESETN_I),
    .code_i(act_baud_ff),
    .tick_o(baud_tick)
  );

  // sequence outputs
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      SERVO_ON_O <= 1'b0;
      PULSE_BLOCK_O <= 1'b0;
      MULTISTEP_SEL_LO_O <= 1'b0;
      MULTISTEP_SEL_HI_O <= 1'b0;
      POWER_STAGE_ON_O <= 1'b0;
      DYNAMIC_BRAKE_O <= 1'b0;
      BAUD_TICK_O <= 1'b0;
      STATION_O <= 5'(STATION_MIN);
    end else begin
      SERVO_ON_O <= eff_servo;
      PULSE_BLOCK_O <= seq_sync_ff[SEQ_BLOCK] || is_forced(act_force_ff, CODE_BLOCK);
      MULTISTEP_SEL_LO_O <= seq_sync_ff[SEQ_MS_LO] || is_forced(act_force_ff, CODE_MS_LO);
      MULTISTEP_SEL_HI_O <= seq_sync_ff[SEQ_MS_HI] || is_forced(act_force_ff, CODE_MS_HI);
      POWER_STAGE_ON_O <= power_on;
      DYNAMIC_BRAKE_O <= (act_dbseq_ff[0] && seq_sync_ff[SEQ_OT]) ||
                         (act_dbseq_ff[1] && !power_on);
      BAUD_TICK_O <= baud_tick;
      STATION_O <= act_station_ff;
    end
  end

  // manual commands: level in speed/torque, one-cycle pulse on rising edge in position
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      fwd_prev_ff <= 1'b0;
      rev_prev_ff <= 1'b0;
      MANUAL_FORWARD_O <= 1'b0;
      MANUAL_REVERSE_O <= 1'b0;
    end else begin
      fwd_prev_ff <= eff_fwd;
      rev_prev_ff <= eff_rev;
      MANUAL_FORWARD_O <= pos_mode ? (eff_fwd && !fwd_prev_ff) : eff_fwd;
      MANUAL_REVERSE_O <= pos_mode ? (eff_rev && !rev_prev_ff) : eff_rev;
    end
  end

  // factor mux; alternatives count only in position control
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      COMP_FACTOR_O <= FACT_W'(FACT_MIN);
    end else begin
      COMP_FACTOR_O <= pos_mode ? fact_ff[cmp_sel] : fact_ff[0];
    end
  end

  // frames to other stations are ignored
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ADDR_MATCH_O <= 1'b0;
    end else begin
      ADDR_MATCH_O <= RX_ADDR_VALID_I && (RX_ADDR_I == act_station_ff);
    end
  end
endmodule

// *** rtl/servo_cfg_pkg.sv ***
// constants, register map and types of the servo parameter block
package servo_cfg_pkg;
  localparam int CLK_HZ = 50_000_000;
  // brake delay unit: 10 ms, in microseconds, and its cycle count
  localparam int BRAKE_UNIT_US = 10_000;
  localparam int TICK_10MS_DEF = BRAKE_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int TICK_W = 20;
  // serial bit rates and their divider counts
  localparam int BAUD_38400 = 38400;
  localparam int BAUD_19200 = 19200;
  localparam int BAUD_9600 = 9600;
  localparam int DIV_W = 13;
  localparam logic [DIV_W-1:0] DIV_38400 = DIV_W'(CLK_HZ / BAUD_38400);
  localparam logic [DIV_W-1:0] DIV_19200 = DIV_W'(CLK_HZ / BAUD_19200);
  localparam logic [DIV_W-1:0] DIV_9600 = DIV_W'(CLK_HZ / BAUD_9600);
  // analog path: 14 bit over +-11.22 V, offset step 1.36 mV
  localparam int CMD_W = 14;
  localparam int CMD_MIN = -8192;
  localparam int CMD_MAX = 8191;
  localparam int OFS_W = 12;
  localparam int OFS_MIN = -2000;
  localparam int OFS_MAX = 2000;
  localparam int OFS_STEP_UV = 1360;
  // arbitrary factory trim value, stands in for the calibrated one
  localparam int OFS_FACTORY_DEF = 16;
  // ranges and reset values
  localparam int DBSEQ_DEF = 0;
  localparam int BRAKE_MAX = 999;
  localparam int SLOT_MAX = 21;
  localparam int FACT_W = 15;
  localparam int FACT_MIN = 1;
  localparam int FACT_MAX = 32767;
  localparam int RAMCNT_MAX = 99;
  localparam int STATION_MIN = 1;
  localparam int STATION_MAX = 31;
  localparam int BAUD_MAX = 2;
  localparam int TRAVEL_MIN = 5;
  localparam int TRAVEL_MAX = 2000;
  localparam int TRAVEL_DEF = 20;
  localparam int SPEED_MIN = 100;
  localparam int SPEED_MAX = 50000;
  localparam int SPEED_DEF = 5000;
  localparam int TIMER_MIN = 1;
  localparam int TIMER_MAX = 500;
  localparam int TIMER_DEF = 50;
  localparam int NV_LIMIT = 100_000;
  localparam int NV_W = 17;
  // positions in the list of parameters that may live in RAM
  localparam int LIST_POS_FACT0 = 1;
  localparam int LIST_POS_FACT1 = 16;
  // forceable input codes
  localparam logic [4:0] CODE_SERVO = 5'h01;
  localparam logic [4:0] CODE_BLOCK = 5'h0B;
  localparam logic [4:0] CODE_REV = 5'h0E;
  localparam logic [4:0] CODE_FWD = 5'h0F;
  localparam logic [4:0] CODE_MS_LO = 5'h11;
  localparam logic [4:0] CODE_MS_HI = 5'h12;
  // control modes
  localparam logic [1:0] MODE_POS = 2'h0;
  localparam logic [1:0] MODE_SPEED = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  // register word indices (byte address = 4 * index)
  localparam logic [5:0] IDX_OFFSET = 6'h00;
  localparam logic [5:0] IDX_DBSEQ = 6'h01;
  localparam logic [5:0] IDX_BRAKE = 6'h02;
  localparam logic [5:0] IDX_FORCE = 6'h03;
  localparam logic [5:0] IDX_FACT0 = 6'h04;
  localparam logic [5:0] IDX_FACT3 = 6'h07;
  localparam logic [5:0] IDX_RAMCNT = 6'h08;
  localparam logic [5:0] IDX_STATION = 6'h09;
  localparam logic [5:0] IDX_BAUD = 6'h0A;
  localparam logic [5:0] IDX_TRAVEL = 6'h0B;
  localparam logic [5:0] IDX_SPEED = 6'h0C;
  localparam logic [5:0] IDX_TIMER = 6'h0D;
  localparam logic [5:0] IDX_CTRL = 6'h0E;
  localparam logic [5:0] IDX_STATUS = 6'h0F;
  localparam logic [5:0] IDX_ACTIVE = 6'h10;
  // control register bits
  localparam int CTRL_RELOAD = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_TEST = 3;
  localparam int CTRL_AUTO_OFS = 4;
  // synchronised sequence input positions
  localparam int SEQ_N = 9;
  localparam int SEQ_SERVO = 0;
  localparam int SEQ_BLOCK = 1;
  localparam int SEQ_FWD = 2;
  localparam int SEQ_REV = 3;
  localparam int SEQ_MS_LO = 4;
  localparam int SEQ_MS_HI = 5;
  localparam int SEQ_CMP_LO = 6;
  localparam int SEQ_CMP_HI = 7;
  localparam int SEQ_OT = 8;
  typedef enum logic [1:0] {ST_RUN, ST_DELAY, ST_OFF} brake_state_type;
endpackage

// *** rtl/brake_delay_timer.sv ***
// base shutoff delay after servo-on falls, counted in 10 ms ticks
`timescale 1ns/100ps
module brake_delay_timer #(
  parameter int TICK_CYCLES = servo_cfg_pkg::TICK_10MS_DEF
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic servo_on_i,
  input wire logic [9:0] delay_i,
  output logic power_on_o
);
  import servo_cfg_pkg::*;
  brake_state_type state_ff;
  logic [TICK_W-1:0] pre_ff;
  logic [9:0] left_ff;
  // prescaler restarts on entry so the first tick is a whole unit away
  always_ff @(posedge clk_i) begin
    if (!resetn_i || state_ff != ST_DELAY || pre_ff == TICK_W'(TICK_CYCLES - 1)) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_OFF;
      left_ff <= '0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (!servo_on_i) begin
            state_ff <= (delay_i == '0) ? ST_OFF : ST_DELAY;
            left_ff <= delay_i;
          end
        end
        ST_DELAY: begin
          if (servo_on_i) begin
            state_ff <= ST_RUN;
          end else if (pre_ff == TICK_W'(TICK_CYCLES - 1)) begin
            left_ff <= left_ff - 1'b1;
            if (left_ff == 10'h001) begin
              state_ff <= ST_OFF;
            end
          end
        end
        ST_OFF: begin
          if (servo_on_i) begin
            state_ff <= ST_RUN;
          end
        end
        default: state_ff <= ST_OFF;
      endcase
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      power_on_o <= 1'b0;
    end else begin
      power_on_o <= (state_ff != ST_OFF) || servo_on_i;
    end
  end
endmodule

// *** rtl/baud_tick_gen.sv ***
// bit-rate enable pulse for the serial link from a selectable divider
`timescale 1ns/100ps
module baud_tick_gen (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] code_i,
  output logic tick_o
);
  import servo_cfg_pkg::*;
  logic [DIV_W-1:0] cnt_ff;
  logic [DIV_W-1:0] div;
  always_comb begin
    case (code_i)
      2'h0: div = DIV_38400;
      2'h1: div = DIV_19200;
      default: div = DIV_9600;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i || cnt_ff >= div - 1'b1) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_ff >= div - 1'b1);
    end
  end
endmodule

// *** bench/servo_param_sequence_config_asserts.sv ***
// port checker of the servo parameter block
`timescale 1ns/100ps
module servo_param_sequence_config_asserts (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic PULSE_BLOCK_I,
  input wire logic PULSE_BLOCK_O,
  input wire logic SERVO_ON_O,
  input wire logic POWER_STAGE_ON_O,
  input wire logic [4:0] RX_ADDR_I,
  input wire logic RX_ADDR_VALID_I,
  input wire logic ADDR_MATCH_O,
  input wire logic [4:0] STATION_O,
  input wire logic BAUD_TICK_O,
  input wire logic [servo_cfg_pkg::FACT_W-1:0] COMP_FACTOR_O
);
  import servo_cfg_pkg::*;
  // edges since reset release, so $past never looks back into reset
  logic [1:0] up_ff;
  always_ff @(posedge CLK_I) begin
    up_ff <= !RESETN_I ? 2'h0 : up_ff + 2'(up_ff != 2'h3);
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  ready_after_setup_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  ready_single_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  err_with_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  block_pin_pass_a: assert property (up_ff == 2'h3 && $past(PULSE_BLOCK_I, 3) |-> PULSE_BLOCK_O)
    else $error("pulse block pin lost");
  power_follow_a: assert property (up_ff == 2'h3 && SERVO_ON_O && $past(SERVO_ON_O, 2) |-> POWER_STAGE_ON_O)
    else $error("power stage off while servo on");
  power_drop_cause_a: assert property ($fell(POWER_STAGE_ON_O) |-> !SERVO_ON_O)
    else $error("power stage dropped with servo on");
  match_cause_a: assert property (ADDR_MATCH_O |-> $past(RX_ADDR_VALID_I) && $past(RX_ADDR_I) == STATION_O)
    else $error("match without own address");
  match_given_a: assert property (RX_ADDR_VALID_I && RX_ADDR_I == STATION_O |=> ADDR_MATCH_O)
    else $error("own address not matched");
  station_valid_a: assert property (STATION_O != 5'h00)
    else $error("station zero");
  tick_single_a: assert property (BAUD_TICK_O |=> !BAUD_TICK_O)
    else $error("baud tick too long");
  factor_nonzero_a: assert property (COMP_FACTOR_O != 15'h0000)
    else $error("factor zero");
endmodule
bind servo_param_sequence_config servo_param_sequence_config_asserts i_chk (
  .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .PULSE_BLOCK_I(PULSE_BLOCK_I), .PULSE_BLOCK_O(PULSE_BLOCK_O), .SERVO_ON_O(SERVO_ON_O),
  .POWER_STAGE_ON_O(POWER_STAGE_ON_O), .RX_ADDR_I(RX_ADDR_I), .RX_ADDR_VALID_I(RX_ADDR_VALID_I),
  .ADDR_MATCH_O(ADDR_MATCH_O), .STATION_O(STATION_O), .BAUD_TICK_O(BAUD_TICK_O), .COMP_FACTOR_O(COMP_FACTOR_O));

// *** bench/host_link_model.sv ***
// host side of the serial link: hands frame addresses to the block
`timescale 1ns/100ps
module host_link_model (
  input wire logic clk_i,
  output logic [4:0] rx_addr_o,
  output logic rx_valid_o
);
  initial begin
    rx_addr_o = 5'h00;
    rx_valid_o = 1'b0;
  end
  // one frame per call; address scrambled after it so stale values never match
  task automatic send(input logic [4:0] a);
    @(posedge clk_i);
    rx_addr_o <= a;
    rx_valid_o <= 1'b1;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_addr_o <= ~a;
  endtask
endmodule

// *** bench/servo_param_sequence_config_tb.sv ***
// self-checking bench of the servo parameter block
`timescale 1ns/100ps
module servo_param_sequence_config_tb;
  import servo_cfg_pkg::*;
  typedef struct {logic w; logic [5:0] idx; logic [31:0] wd; logic [31:0] ex;} row_type;
  localparam int TK = 10;
  logic clk, rstn, psel, pen, pwr, pready, pslverr, err, rxv, son, blk, manual_forward, rev, mlo, mhi, pwr_on, db, match, tick;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] pin;
  logic [CMD_W-1:0] adc, cmd;
  logic [4:0] rxa, station;
  logic [FACT_W-1:0] fact;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  int per [3] = '{CLK_HZ / BAUD_38400, CLK_HZ / BAUD_19200, CLK_HZ / BAUD_9600};
  row_type rows [] = '{
    '{1'b0, IDX_OFFSET, 32'h0, 32'(OFS_FACTORY_DEF)}, // trim default
    '{1'b0, IDX_FACT3, 32'h0, 32'h1}, // default
    '{1'b0, IDX_STATION, 32'h0, 32'h1}, // default
    '{1'b0, IDX_TIMER, 32'h0, 32'h32}, // default
    '{1'b1, IDX_OFFSET, 32'h09C4, 32'h07D0}, // clamp
    '{1'b1, IDX_BRAKE, 32'h05DC, 32'h03E7}, // clamp
    '{1'b1, IDX_FACT3, 32'h0, 32'h1}, // clamp
    '{1'b1, IDX_FACT3, 32'h9C40, 32'h7FFF}, // clamp
    '{1'b1, IDX_RAMCNT, 32'hC8, 32'h63}, // clamp
    '{1'b1, IDX_STATION, 32'h28, 32'h1F}, // clamp
    '{1'b1, IDX_BAUD, 32'h3, 32'h2}, // clamp
    '{1'b1, IDX_SPEED, 32'hEA60, 32'hC350} // clamp
  };
  servo_param_sequence_config #(.TICK_10MS_CYCLES(TK)) i_dut (
    .CLK_I(clk), .RESETN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SERVO_ON_I(pin[SEQ_SERVO]),
    .PULSE_BLOCK_I(pin[SEQ_BLOCK]), .MANUAL_FORWARD_I(pin[SEQ_FWD]), .MANUAL_REVERSE_I(pin[SEQ_REV]),
    .MULTISTEP_SEL_LO_I(pin[SEQ_MS_LO]), .MULTISTEP_SEL_HI_I(pin[SEQ_MS_HI]), .COMP_SEL_LO_I(pin[SEQ_CMP_LO]),
    .COMP_SEL_HI_I(pin[SEQ_CMP_HI]), .OVERTRAVEL_I(pin[SEQ_OT]), .ADC_DATA_I(adc), .RX_ADDR_I(rxa),
    .RX_ADDR_VALID_I(rxv), .CMD_O(cmd), .SERVO_ON_O(son), .PULSE_BLOCK_O(blk), .MANUAL_FORWARD_O(manual_forward),
    .MANUAL_REVERSE_O(rev), .MULTISTEP_SEL_LO_O(mlo), .MULTISTEP_SEL_HI_O(mhi), .COMP_FACTOR_O(fact),
    .POWER_STAGE_ON_O(pwr_on), .DYNAMIC_BRAKE_O(db), .ADDR_MATCH_O(match), .BAUD_TICK_O(tick), .STATION_O(station));
  host_link_model i_host (.clk_i(clk), .rx_addr_o(rxa), .rx_valid_o(rxv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask
  // edges until the signal shows the wanted level, bounded
  task automatic till(ref logic s, input logic v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s !== v && n < 6000);
  endtask
  task automatic cnt(ref logic s, input int c);
    n = 0;
    repeat (c) begin
      @(posedge clk);
      n += int'(s === 1'b1);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // the run needs some 20k cycles; five times that means a hang
  initial begin
    wt(100000);
    n_errors++;
    give_verdict();
  end
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin = 9'h000;
    adc = 14'h1FFE;
    wt(12);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].idx, rows[i].wd);
      if (rows[i].w) apb(1'b0, rows[i].idx, 32'h0);
      chk(rd, rows[i].ex);
    end
    apb(1'b0, 6'h11, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    $display("registers done");
    wr(IDX_OFFSET, 32'h5);
    wt(4);
    chk(cmd, 14'h1FFF); // sum saturates
    adc <= 14'h0064;
    wr(IDX_CTRL, 32'h10);
    wt(4);
    chk(cmd, 14'h0069); // one count a step, no trim outside test
    wr(IDX_CTRL, 32'h8);
    wr(IDX_CTRL, 32'h18);
    wt(4);
    chk(cmd, 14'h0); // trim cancels input
    wr(IDX_OFFSET, 32'hFFFF_F830);
    adc <= 14'h0;
    wt(4);
    chk(cmd, 14'h3830); // lowest offset
    $display("offset done");
    wr(IDX_STATION, 32'h5);
    wt(2);
    chk(station, 5'h01); // held until reload
    wr(IDX_CTRL, 32'h1);
    wt(2);
    chk(station, 5'h05);
    i_host.send(5'h05);
    cnt(match, 4);
    chk(n, 1);
    i_host.send(5'h06);
    cnt(match, 4);
    chk(n, 0);
    for (int i = 0; i < 3; i++) begin
      wr(IDX_BAUD, 32'(i));
      wr(IDX_CTRL, 32'h1);
      till(tick, 1'b1);
      till(tick, 1'b0);
      till(tick, 1'b1);
      chk(n + 1, per[i]);
    end
    $display("link done");
    wr(IDX_BRAKE, 32'h3);
    pin[SEQ_SERVO] <= 1'b1;
    wt(8);
    chk(pwr_on, 1'b1);
    pin[SEQ_SERVO] <= 1'b0;
    till(pwr_on, 1'b0);
    chk(n >= 3 * TK && n <= 3 * TK + 8, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(IDX_DBSEQ, 32'(c));
      wr(IDX_CTRL, 32'h1);
      pin[SEQ_OT] <= 1'b1;
      wt(6);
      chk(db, c != 0);
      pin[SEQ_OT] <= 1'b0;
      wt(6);
      chk(db, c > 1);
    end
    $display("brake done");
    pin[SEQ_BLOCK] <= 1'b1;
    pin[SEQ_MS_HI] <= 1'b1;
    wt(5);
    chk({blk, mhi}, 2'b11);
    pin <= 9'h000;
    wr(IDX_FORCE, 32'h1211_0B01);
    wr(IDX_CTRL, 32'h1);
    wt(5);
    chk({son, blk, mlo, mhi}, 4'hF);
    wr(IDX_FORCE, 32'h0E0F);
    wr(IDX_CTRL, 32'h1);
    wt(5);
    chk({manual_forward, rev}, 2'b00); // never forced in position mode
    wr(IDX_CTRL, 32'h3);
    wt(5);
    chk({manual_forward, rev}, 2'b11);
    wr(IDX_FORCE, 32'h0);
    wr(IDX_CTRL, 32'h1);
    wt(4); // old speed-mode level drains first
    pin[SEQ_FWD] <= 1'b1;
    cnt(manual_forward, 12);
    chk(n, 1); // one pulse per rising edge
    $display("forcing done");
    for (int i = 0; i < 4; i++) wr(IDX_FACT0 + 6'(i), 32'(i + 10));
    for (int i = 0; i < 4; i++) begin
      pin[SEQ_CMP_LO] <= i[0];
      pin[SEQ_CMP_HI] <= i[1];
      wt(6);
      chk(fact, i + 10);
    end
    wr(IDX_CTRL, 32'h5);
    wt(4);
    chk({fact, manual_forward}, 32'h15); // first factor and level outside position
    rstn <= 1'b0;
    wt(3);
    rstn <= 1'b1;
    wt(1);
    chk({station, fact}, {5'h01, 15'h0001});
    $display("factor and reset done");
    give_verdict();
  end
endmodule
